/* rtl/lin_diag_defines.svh */
// Register offsets, command layouts, flag positions and timing constants
`ifndef LIN_DIAG_DEFINES_SVH
`define LIN_DIAG_DEFINES_SVH
`define ADDR_CMD_BYTE 8'h00
`define ADDR_CMD_EXEC 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_RESP_LO 8'h0c
`define ADDR_RESP_HI 8'h10
`define OP_CONFIG 8'ha0
`define OP_START 8'ha1
`define OP_SEND 8'ha2
`define NUM_CH 4
`define CMD_DEPTH 72
`define REQ_DEPTH 64
`define SR_ENTRIES 2
`define SR_BYTES 20
`define SR_FLAGS_POS 16
`define B_CH 0
`define CFG_TYPE 1
`define CFG_NAD 4
`define CFG_RESP_TO 6
`define CFG_PEND_TO 8
`define CFG_RETRY 10
`define CFG_KA_EN 12
`define CFG_KA_REPLY 13
`define CFG_KA_PERIOD 14
`define CFG_KA_LEN 19
`define CFG_KA_DATA 20
`define CFG_SR_COUNT 28
`define CFG_SR_BASE 29
`define B_MODE 1
`define MODE_FUNC 0
`define MODE_NORESP 7
`define ST_LEN 2
`define ST_DATA 4
`define SR_SEND 2
`define SR_APPEND 3
`define SR_LEN 6
`define SR_DATA 8
`define FL_REPEAT 0
`define FL_PENDING 1
`define FL_DEFAULT 2
`define FL_LAST 3
`define FL_FILTER 4
`define FUNC_NAD 8'h7e
`define ERR_NONE 4'h0
`define ERR_NOSESSION 4'h1
`define ERR_NOTASK 4'h2
`define ERR_TIMEOUT 4'h3
`define ERR_BADCMD 4'h4
`define ERR_BADCH 4'h5
`define MS_NS 1000000
`define CLK_NS 25
`endif

/* rtl/lin_diag_pkg.sv */
// Shared types of the diagnostic engine
package lin_diag_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_COPY, ST_TX, ST_WAIT} state_t;
endpackage

/* rtl/special_response_match.sv */
// Masked comparison of one received frame against the special-response table
`timescale 1ns/1ps
`include "lin_diag_defines.svh"
module special_response_match
    import lin_diag_pkg::*;
(
    input wire logic [63:0] frame,
    input wire logic [`SR_ENTRIES*64-1:0] mask_flat,
    input wire logic [`SR_ENTRIES*64-1:0] data_flat,
    input wire logic [`SR_ENTRIES*8-1:0] flags_flat,
    input wire logic [7:0] entry_count,
    output logic hit,
    output logic [7:0] hit_flags,
    output logic discard
);
    logic [`SR_ENTRIES-1:0] eq, live, drop;
    logic [`SR_ENTRIES*8-1:0] fl_or;

    // Each live entry compares the masked frame with its data bytes
    genvar g;
    generate
        for (g = 0; g < `SR_ENTRIES; g++) begin : g_ent
            assign live[g] = (8'(g) < entry_count);
            assign eq[g] = live[g] &&
                ((frame & mask_flat[g*64 +: 64]) == data_flat[g*64 +: 64]);
            // A filter entry drops frames that do not fit it
            assign drop[g] = live[g] && !eq[g] && flags_flat[g*8 + `FL_FILTER];
            if (g == 0) begin : g_first
                assign fl_or[7:0] = eq[0] ? flags_flat[7:0] : 8'h00;
            end else begin : g_rest
                assign fl_or[g*8 +: 8] = fl_or[(g-1)*8 +: 8] |
                    (eq[g] ? flags_flat[g*8 +: 8] : 8'h00);
            end
        end
    endgenerate

    assign hit = |eq;
    assign hit_flags = fl_or[(`SR_ENTRIES-1)*8 +: 8] & 8'h1f; // Reserved bits 5-7 ignored
    assign discard = |drop;
endmodule

/* rtl/lin_diag_session_control.sv */
// Function
// - Table entry: 8 mask, 8 data, flags
// - Masked received frame compared with entry data
// - Match flags: repeat, pending, default, last (the last flag has no effect here)
// - Filter flag discards non-matching frames
// - Config byte 4 is node address
// - Bytes 6-7 response timeout in ms
// - Bytes 8-9 pending timeout in ms
// - Bytes 10-11 repeat count on timeout
// - Keep-alive enable, reply flag, period
// - Keep-alive length and payload bytes
// - Nonzero type starts the diagnostic task
// - Type zero stops task, frees sessions
// - Start-session opens channel session
// - Mode: physical/functional, bit7 no response
// - Start length; zero sends nothing
// - Command byte 0 selects channel
// - Physical targets one unit, functional broadcasts
// - Send byte 2 transmit, byte 3 append
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "lin_diag_defines.svh"
module lin_diag_session_control
    import lin_diag_pkg::*;
#(
    parameter int MS_CYCLES = `MS_NS / `CLK_NS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic [7:0] tx_node_address,
    output logic tx_functional,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic [63:0] rx_frame,
    output logic resp_valid,
    output logic [63:0] resp_frame
);
    logic rst_meta_r, rstn;
    logic ph_wr_r;
    logic [7:0] ph_addr_r;
    byte_t cmd_buf [0:`CMD_DEPTH-1];
    byte_t req_buf [0:`REQ_DEPTH-1];
    byte_t ka_data [0:7];
    logic [6:0] cmd_ptr_r, req_len_r, src_r, cnt_r, tx_idx_r, tx_len_r;
    byte_t opcode_r, node_address_r, ka_len_r, sr_count_r;
    logic [15:0] resp_to_r, pend_to_r, retries_r, retry_left_r, ka_period_r;
    logic [15:0] wait_ms_r, ka_ms_r;
    logic [31:0] ms_cnt_r;
    logic task_r, ka_en_r, ka_reply_r, ka_src_r, send_r, resp_exp_r, pending_r;
    logic [`NUM_CH-1:0] session_r;
    logic [3:0] err_r;
    logic [`SR_ENTRIES*64-1:0] sr_mask_r, sr_data_r;
    logic [`SR_ENTRIES*8-1:0] sr_flags_r;
    state_t st_r;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rstn <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rstn <= rst_meta_r;
        end
    end

    // Little-endian 16-bit field from the command buffer
    function automatic logic [15:0] cb16(input int idx);
        cb16 = {cmd_buf[idx+1], cmd_buf[idx]};
    endfunction

    // AHB-Lite decode; zero wait states, always OKAY
    wire addr_ok = hsel && htrans[1] && hready;
    wire idle = (st_r == ST_IDLE);
    wire wr_byte = ph_wr_r && (ph_addr_r == `ADDR_CMD_BYTE) && idle;
    wire wr_exec = ph_wr_r && (ph_addr_r == `ADDR_CMD_EXEC) && idle;
    wire [31:0] status_w = {7'h00, st_r, 4'h0, 4'(session_r), err_r,
                            cmd_ptr_r, pending_r, task_r, !idle};
    wire [31:0] rd_mux = (haddr[7:0] == `ADDR_STATUS) ? status_w :
                         (haddr[7:0] == `ADDR_RESP_LO) ? resp_frame[31:0] :
                         (haddr[7:0] == `ADDR_RESP_HI) ? resp_frame[63:32] : 32'h0000_0000;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ph_wr_r <= 1'b0;
            ph_addr_r <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            ph_wr_r <= addr_ok && hwrite;
            ph_addr_r <= haddr[7:0];
            hrdata <= (addr_ok && !hwrite) ? rd_mux : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Command bytes are staged one per write; writes while busy are dropped
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd_ptr_r <= 7'h00;
        end else if (wr_exec) begin
            cmd_ptr_r <= 7'h00;
        end else if (wr_byte && cmd_ptr_r < 7'(`CMD_DEPTH)) begin
            cmd_ptr_r <= cmd_ptr_r + 7'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (wr_byte && cmd_ptr_r < 7'(`CMD_DEPTH)) begin
            cmd_buf[cmd_ptr_r] <= hwdata[7:0];
        end
    end

    // Command fields, channel in byte 0
    wire [7:0] ex_ch = cmd_buf[`B_CH];
    wire ch_ok = ex_ch < 8'(`NUM_CH);
    wire [1:0] ch_i = ex_ch[1:0];
    wire [15:0] st_len = cb16(`ST_LEN);
    wire [15:0] sr_len = cb16(`SR_LEN);
    wire [6:0] st_cnt = (st_len > 16'(`REQ_DEPTH)) ? 7'(`REQ_DEPTH) : st_len[6:0];
    wire [6:0] sr_cnt = (sr_len > 16'(`REQ_DEPTH)) ? 7'(`REQ_DEPTH) : sr_len[6:0];
    wire cfg_type_zero = (cmd_buf[`CFG_TYPE] == 8'h00);
    wire send_no_sess = !ch_ok || !session_r[ch_i];

    // Millisecond tick from the 40 MHz clock
    wire ms_tick = (ms_cnt_r == MS_CYCLES - 1);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ms_cnt_r <= 32'h0000_0000;
        end else begin
            ms_cnt_r <= ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
        end
    end

    // Response screening against the special-response table
    logic sr_hit, sr_discard;
    logic [7:0] sr_fl;
    special_response_match u_match (
        .frame(rx_frame),
        .mask_flat(sr_mask_r),
        .data_flat(sr_data_r),
        .flags_flat(sr_flags_r),
        .entry_count(sr_count_r),
        .hit(sr_hit),
        .hit_flags(sr_fl),
        .discard(sr_discard)
    );
    wire rx_take = (st_r == ST_WAIT) && rx_valid && !sr_discard;
    wire rx_repeat = rx_take && sr_hit && sr_fl[`FL_REPEAT];
    wire rx_pend = rx_take && sr_hit && !sr_fl[`FL_REPEAT] && sr_fl[`FL_PENDING];
    wire rx_dflt = rx_take && sr_hit && sr_fl[`FL_DEFAULT];
    wire rx_final = rx_take && !rx_repeat && !rx_pend && !rx_dflt;
    wire [15:0] limit = pending_r ? pend_to_r : resp_to_r;
    wire timeout = (st_r == ST_WAIT) && !rx_take && (wait_ms_r >= limit);
    wire ka_due = idle && !wr_exec && task_r && ka_en_r && (ka_ms_r >= ka_period_r);

    // Transmit byte stream; next byte loaded as the current one is taken
    wire tx_fire = tx_valid && tx_ready;
    wire [6:0] sel_idx = tx_fire ? tx_idx_r + 7'h01 : tx_idx_r;
    wire [7:0] sel_byte = ka_src_r ? ka_data[sel_idx[2:0]] : req_buf[sel_idx[5:0]];
    wire retx = rx_repeat || (timeout && retry_left_r != 16'h0000);

    // Configuration load on a nonzero type
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            node_address_r <= 8'h00;
            resp_to_r <= 16'h0000;
            pend_to_r <= 16'h0000;
            retries_r <= 16'h0000;
            ka_en_r <= 1'b0;
            ka_reply_r <= 1'b0;
            ka_period_r <= 16'h0000;
            ka_len_r <= 8'h00;
            sr_count_r <= 8'h00;
            sr_mask_r <= '0;
            sr_data_r <= '0;
            sr_flags_r <= '0;
        end else if (st_r == ST_EXEC && opcode_r == `OP_CONFIG && !cfg_type_zero) begin
            node_address_r <= cmd_buf[`CFG_NAD];
            resp_to_r <= cb16(`CFG_RESP_TO);
            pend_to_r <= cb16(`CFG_PEND_TO);
            retries_r <= cb16(`CFG_RETRY);
            ka_en_r <= cmd_buf[`CFG_KA_EN][0];
            ka_reply_r <= cmd_buf[`CFG_KA_REPLY][0];
            ka_period_r <= cb16(`CFG_KA_PERIOD);
            ka_len_r <= cmd_buf[`CFG_KA_LEN];
            sr_count_r <= cmd_buf[`CFG_SR_COUNT];
            for (int e = 0; e < `SR_ENTRIES; e++) begin
                for (int b = 0; b < 8; b++) begin
                    sr_mask_r[e*64+b*8 +: 8] <= cmd_buf[`CFG_SR_BASE+e*`SR_BYTES+b];
                    sr_data_r[e*64+b*8 +: 8] <= cmd_buf[`CFG_SR_BASE+e*`SR_BYTES+8+b];
                end
                sr_flags_r[e*8 +: 8] <=
                    cmd_buf[`CFG_SR_BASE+e*`SR_BYTES+`SR_FLAGS_POS];
            end
        end
    end
    always_ff @(posedge clk) begin
        if (st_r == ST_EXEC && opcode_r == `OP_CONFIG && !cfg_type_zero) begin
            for (int b = 0; b < 8; b++) begin
                ka_data[b] <= cmd_buf[`CFG_KA_DATA+b];
            end
        end
        if (st_r == ST_COPY && cnt_r != 7'h00 && req_len_r < 7'(`REQ_DEPTH)) begin
            req_buf[req_len_r[5:0]] <= cmd_buf[src_r];
        end
    end

    // Command execution, copy, transmit and response wait
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= ST_IDLE;
            opcode_r <= 8'h00;
            task_r <= 1'b0;
            session_r <= '0;
            err_r <= `ERR_NONE;
            req_len_r <= 7'h00;
            src_r <= 7'h00;
            cnt_r <= 7'h00;
            send_r <= 1'b0;
            resp_exp_r <= 1'b0;
            ka_src_r <= 1'b0;
            tx_functional <= 1'b0;
            tx_node_address <= 8'h00;
            tx_idx_r <= 7'h00;
            tx_len_r <= 7'h00;
            retry_left_r <= 16'h0000;
            pending_r <= 1'b0;
            resp_valid <= 1'b0;
            resp_frame <= 64'h0;
        end else begin
            resp_valid <= 1'b0;
            unique case (st_r)
                ST_IDLE: begin
                    if (wr_exec) begin
                        opcode_r <= hwdata[7:0];
                        st_r <= ST_EXEC;
                    end else if (ka_due) begin
                        ka_src_r <= 1'b1;
                        tx_len_r <= (ka_len_r > 8'h08) ? 7'h08 : ka_len_r[6:0];
                        resp_exp_r <= ka_reply_r;
                        tx_functional <= 1'b0;
                        tx_node_address <= node_address_r;
                        tx_idx_r <= 7'h00;
                        retry_left_r <= retries_r;
                        pending_r <= 1'b0;
                        st_r <= (ka_len_r == 8'h00) ? ST_IDLE : ST_TX;
                    end
                end
                ST_EXEC: begin
                    err_r <= `ERR_NONE;
                    st_r <= ST_IDLE;
                    if (opcode_r == `OP_CONFIG) begin
                        task_r <= !cfg_type_zero;
                        if (cfg_type_zero) begin
                            session_r <= '0;
                        end
                    end else if (opcode_r == `OP_START) begin
                        if (!task_r) begin
                            err_r <= `ERR_NOTASK;
                        end else if (!ch_ok) begin
                            err_r <= `ERR_BADCH;
                        end else begin
                            session_r[ch_i] <= 1'b1;
                            tx_functional <= cmd_buf[`B_MODE][`MODE_FUNC];
                            tx_node_address <= cmd_buf[`B_MODE][`MODE_FUNC] ?
                                `FUNC_NAD : node_address_r;
                            resp_exp_r <= !cmd_buf[`B_MODE][`MODE_NORESP];
                            req_len_r <= 7'h00;
                            src_r <= 7'(`ST_DATA);
                            cnt_r <= st_cnt;
                            send_r <= (st_len != 16'h0000);
                            st_r <= ST_COPY;
                        end
                    end else if (opcode_r == `OP_SEND) begin
                        if (send_no_sess) begin
                            err_r <= `ERR_NOSESSION;
                        end else begin
                            tx_functional <= cmd_buf[`B_MODE][`MODE_FUNC];
                            tx_node_address <= cmd_buf[`B_MODE][`MODE_FUNC] ?
                                `FUNC_NAD : node_address_r;
                            resp_exp_r <= !cmd_buf[`B_MODE][`MODE_NORESP];
                            if (!cmd_buf[`SR_APPEND][0]) begin
                                req_len_r <= 7'h00;
                            end
                            src_r <= 7'(`SR_DATA);
                            cnt_r <= sr_cnt;
                            send_r <= cmd_buf[`SR_SEND][0];
                            st_r <= ST_COPY;
                        end
                    end else begin
                        err_r <= `ERR_BADCMD;
                    end
                end
                ST_COPY: begin
                    if (cnt_r != 7'h00 && req_len_r < 7'(`REQ_DEPTH)) begin
                        req_len_r <= req_len_r + 7'h01;
                        src_r <= src_r + 7'h01;
                        cnt_r <= cnt_r - 7'h01;
                    end else begin
                        // Send with nothing buffered stays silent
                        ka_src_r <= 1'b0;
                        tx_len_r <= req_len_r;
                        tx_idx_r <= 7'h00;
                        retry_left_r <= retries_r;
                        pending_r <= 1'b0;
                        st_r <= (send_r && req_len_r != 7'h00) ? ST_TX : ST_IDLE;
                    end
                end
                ST_TX: begin
                    if (tx_fire) begin
                        tx_idx_r <= tx_idx_r + 7'h01;
                        if (tx_last) begin
                            st_r <= resp_exp_r ? ST_WAIT : ST_IDLE;
                        end
                    end
                end
                ST_WAIT: begin
                    if (retx) begin
                        if (!rx_repeat) begin
                            retry_left_r <= retry_left_r - 16'h0001;
                        end
                        tx_idx_r <= 7'h00;
                        st_r <= ST_TX;
                    end else if (timeout) begin
                        err_r <= `ERR_TIMEOUT;
                        st_r <= ST_IDLE;
                    end else if (rx_pend) begin
                        pending_r <= 1'b1;
                    end else if (rx_final) begin
                        resp_valid <= 1'b1;
                        resp_frame <= rx_frame;
                        st_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Byte presentation towards the link
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
        end else begin
            tx_valid <= (st_r == ST_TX) && !(tx_fire && tx_last);
            tx_data <= sel_byte;
            tx_last <= (sel_idx == tx_len_r - 7'h01);
        end
    end

    // Response and keep-alive millisecond counters; restart on each transmit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_ms_r <= 16'h0000;
            ka_ms_r <= 16'h0000;
        end else begin
            if (st_r != ST_WAIT || rx_pend) begin
                wait_ms_r <= 16'h0000;
            end else if (ms_tick && wait_ms_r != 16'hffff) begin
                wait_ms_r <= wait_ms_r + 16'h0001;
            end
            if (!task_r || st_r == ST_TX) begin
                ka_ms_r <= 16'h0000; // Each transmitted frame also keeps the unit awake
            end else if (ms_tick && ka_ms_r != 16'hffff) begin
                ka_ms_r <= ka_ms_r + 16'h0001;
            end
        end
    end

    // Checks on the command engine
    repeat_request_a: assert property (@(posedge clk) disable iff (!rstn)
        rx_repeat |=> st_r == ST_TX && tx_idx_r == 7'h00)
        else $error("repeat flag did not restart the request");
    filter_drop_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == ST_WAIT && rx_valid && sr_discard && !timeout) |=>
            !resp_valid && st_r != ST_IDLE)
        else $error("filtered frame was not discarded");
    pending_switch_a: assert property (@(posedge clk) disable iff (!rstn)
        rx_pend |=> pending_r && wait_ms_r == 16'h0000)
        else $error("pending flag did not switch timing");
    retry_count_a: assert property (@(posedge clk) disable iff (!rstn)
        (timeout && retry_left_r != 16'h0000) |=>
            st_r == ST_TX && retry_left_r == $past(retry_left_r) - 16'h0001)
        else $error("timeout retry miscounted");
    task_start_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == ST_EXEC && opcode_r == `OP_CONFIG && !cfg_type_zero) |=> task_r)
        else $error("task not started");
    task_stop_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == ST_EXEC && opcode_r == `OP_CONFIG && cfg_type_zero) |=>
            !task_r && session_r == '0)
        else $error("task not stopped");
    no_session_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == ST_EXEC && opcode_r == `OP_SEND && send_no_sess) |=>
            err_r == `ERR_NOSESSION && st_r == ST_IDLE ##1 !tx_valid)
        else $error("send without session not refused");
    empty_start_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == ST_EXEC && opcode_r == `OP_START && task_r && ch_ok &&
         st_len == 16'h0000) |=> st_r == ST_COPY ##1 st_r == ST_IDLE && !tx_valid)
        else $error("empty start-session transmitted");
    target_nad_a: assert property (@(posedge clk) disable iff (!rstn)
        tx_valid && !ka_src_r |-> tx_node_address == (tx_functional ? `FUNC_NAD : node_address_r))
        else $error("wrong target address");
    cov_session_c: cover property (@(posedge clk) disable iff (!rstn)
        st_r == ST_EXEC && opcode_r == `OP_START ##[1:80] tx_valid);
    cov_response_c: cover property (@(posedge clk) disable iff (!rstn) rx_final);
    cov_retry_c: cover property (@(posedge clk) disable iff (!rstn) timeout && retx);
    cov_keepalive_c: cover property (@(posedge clk) disable iff (!rstn) ka_due);
endmodule

/* verif/lin_slave_model.sv */
// Behavioural LIN slave unit that answers diagnostic requests
`timescale 1ns/1ps
module lin_slave_model (
    input wire logic clk,
    input wire logic answer,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready = 1'b0,
    output logic rx_valid = 1'b0,
    output logic [63:0] rx_frame = '0,
    output int frames = 0
);
    logic [7:0] sid_r = 8'h00;
    logic first_r = 1'b1;
    int wait_r = 0;
    // Ready every other cycle, so the sender must hold its offer
    always @(posedge clk) begin
        tx_ready <= ~tx_ready;
        rx_valid <= 1'b0;
        rx_frame <= ~rx_frame;  // Idle frame lines toggle, showing the last reply again every other cycle
        if (wait_r > 0) wait_r <= wait_r - 1;
        if (tx_valid && tx_ready) begin
            if (first_r) sid_r <= tx_data;
            first_r <= tx_last;
            if (tx_last) frames <= frames + 1;
            if (tx_last && answer) wait_r <= 6;
        end
        if (wait_r == 1) begin
            rx_valid <= 1'b1;
            rx_frame <= {56'h0, sid_r | 8'h40};  // Positive reply to the service id
        end
    end
endmodule

/* verif/tb.sv */
// Self-checking bench for the LIN diagnostic session engine
`timescale 1ns/1ps
`include "lin_diag_defines.svh"
module tb;
    import lin_diag_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata, q;
    logic hreadyout, hresp, tx_valid, tx_last, tx_functional, tx_ready, rx_valid, resp_valid;
    logic [7:0] tx_data, tx_node_address, nad_seen;
    logic [63:0] rx_frame, resp_frame;
    logic answer = 1'b1;
    logic func_seen;
    int frames, f, fail_count = 0, checks_done = 0;
    always #12.5 clk = ~clk;
    // Short millisecond keeps timeout waits to a few dozen cycles
    lin_diag_session_control #(.MS_CYCLES(8)) u_lin_diag_session_control (.clk, .resetn,
        .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .tx_valid, .tx_data, .tx_last, .tx_node_address,
        .tx_functional, .tx_ready, .rx_valid, .rx_frame, .resp_valid, .resp_frame);
    lin_slave_model u_lin_slave_model (.clk, .answer, .tx_valid, .tx_data, .tx_last,
        .tx_ready, .rx_valid, .rx_frame, .frames);
    // Target of the last byte taken by the link
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            nad_seen <= tx_node_address;
            func_seen <= tx_functional;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // One single AHB transfer; read data taken at the data-phase edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // Load n command bytes (byte i at bits 8i), execute, poll busy away
    task automatic cmd(input int n, input logic [255:0] v, input byte_t op);
        f = frames;
        for (int i = 0; i < n; i++) bus(1'b1, 32'h0, {24'h0, v[8*i +: 8]});
        bus(1'b1, 32'h4, {24'h0, op});
        q = 32'h1;
        for (int i = 0; i < 400 && q[0] !== 1'b0; i++) bus(1'b0, 32'h8, 32'h0);
    endtask
    task automatic t_config();
        cmd(29, 256'h000100040002002100000100, `OP_CONFIG);
        chk("task", 32'h1, 32'(q[1]));
        $display("test config done");
    endtask
    task automatic t_send(input logic sess);
        cmd(9, 256'h3e0001000000010000, `OP_SEND);
        chk("err", sess ? 32'h0 : 32'h1, 32'(q[13:10]));
        chk("frames", 32'(f + sess), 32'(frames));
        $display("test send done");
    endtask
    task automatic t_start();
        cmd(6, 256'h102200020000, `OP_START);
        chk("session", 32'h1, 32'(q[14]));
        chk("nad", 32'h21, 32'(nad_seen));
        chk("func", 32'h0, 32'(func_seen));
        bus(1'b0, 32'hc, 32'h0);
        chk("resp", 32'h62, 32'(q[7:0]));
        t_send(1'b1);
        bus(1'b0, 32'hc, 32'h0);
        chk("resp2", 32'h7e, 32'(q[7:0]));
        cmd(9, 256'h220001000000000000, `OP_SEND);
        chk("buffered", 32'(f), 32'(frames));
        cmd(9, 256'h100001000001010000, `OP_SEND);
        chk("appended", 32'(f + 1), 32'(frames));
        bus(1'b0, 32'hc, 32'h0);
        chk("resp3", 32'h62, 32'(q[7:0]));
        $display("test start done");
    endtask
    task automatic t_silent();
        answer <= 1'b0;
        cmd(5, 256'h3e00010101, `OP_START);
        chk("repeats", 32'(f + 2), 32'(frames));
        chk("err", 32'h3, 32'(q[13:10]));
        chk("nad", 32'h7e, 32'(nad_seen));
        chk("func", 32'h1, 32'(func_seen));
        cmd(5, 256'h3e00018102, `OP_START);
        chk("nowait", 32'(f + 1), 32'(frames));
        chk("err", 32'h0, 32'(q[13:10]));
        cmd(4, 256'h03, `OP_START);
        chk("empty", 32'(f), 32'(frames));
        chk("empty_sess", 32'h1, 32'(q[17]));
        $display("test silent done");
    endtask
    // Keep-alive with a short period: exactly one unanswered frame in the wait
    task automatic t_keepalive();
        cmd(29, 256'h3e0100000000200001000100040002002100000100, `OP_CONFIG);
        repeat (300) @(posedge clk);
        chk("keepalive", 32'(f + 1), 32'(frames));
        $display("test keepalive done");
    endtask
    task automatic t_stop();
        cmd(29, 256'h0, `OP_CONFIG);
        chk("task", 32'h0, 32'(q[1]));
        chk("sessions", 32'h0, 32'(q[17:14]));
        $display("test stop done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // A hang counts as a mismatch and ends the run
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        t_config();
        t_send(1'b0);
        t_start();
        t_silent();
        t_keepalive();
        t_stop();
        test_done();
    end
endmodule
